// ### core/dspadc_fifo.sv
`timescale 1ns/100ps
// Flip-flop buffer with valid/ready on both sides and honest full and empty.
module dspadc_fifo #(
	parameter int WIDTH = dspadc_pkg::SAMPLE_W,
	parameter int DEPTH = dspadc_pkg::FIFO_DEPTH
) (
	input wire logic    clk,
	input wire logic    rst,
	dspadc_stream_if.snk inPort,
	dspadc_stream_if.src outPort
);
	import dspadc_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];  // Storage, addressed by the pointers.
	logic [PTR_W-1:0] wrPtr;        // Next slot to write.
	logic [PTR_W-1:0] rdPtr;        // Oldest stored word.
	logic [PTR_W:0]   count;        // Number of stored words.
	logic             wrFire;       // A word enters this cycle.
	logic             rdFire;       // A word leaves this cycle.

	// Advances a pointer with wrap at the buffer depth.
	function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'h1);
	endfunction : nextPtr

	// Full refuses writes, empty withholds valid.
	assign inPort.ready  = (count != (PTR_W + 1)'(DEPTH));
	assign outPort.valid = (count != '0);
	assign outPort.data  = mem[rdPtr];
	assign wrFire        = inPort.valid && inPort.ready;
	assign rdFire        = outPort.valid && outPort.ready;

	// Stores an accepted word; storage needs no reset.
	always_ff @(posedge clk) begin
		if (wrFire) begin
			mem[wrPtr] <= inPort.data;
		end
	end

	// Pointer and occupancy bookkeeping.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (wrFire) begin
				wrPtr <= nextPtr(wrPtr);
			end
			if (rdFire) begin
				rdPtr <= nextPtr(rdPtr);
			end
			if (wrFire && !rdFire) begin
				count <= (PTR_W + 1)'(count + 1'h1);
			end else if (rdFire && !wrFire) begin
				count <= (PTR_W + 1)'(count - 1'h1);
			end
		end
	end
endmodule : dspadc_fifo

// ### core/dspadc_pkg.sv
// Shared constants of the dual simultaneous-sampling converter host port.
package dspadc_pkg;

	// Width of one conversion result on the parallel bus.
	localparam int SAMPLE_W     = 14;
	// Depth of the result buffer between the converter and the read port.
	localparam int FIFO_DEPTH   = 32;

	// System clock period in nanoseconds (50 MHz).
	localparam int CLK_PERIOD_NS = 20;
	// Longest time from conversion start to results ready, 5.2 us.
	localparam int CONV_TIME_NS  = 5200;
	// Longest time rounds down to whole cycles.
	localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
	// Cycles spent writing the two results into the buffer.
	localparam int PUSH_CYCLES   = 2;
	// Width of the conversion cycle counter.
	localparam int CNT_W         = $clog2(CONV_CYCLES + 1);
	// Last count value of the converting phase.
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - PUSH_CYCLES - 1);
	// Counter start value.
	localparam logic [CNT_W-1:0] CNT_ZERO  = '0;

	// Idle level of an active-low pin held in a synchroniser at reset.
	localparam logic PIN_IDLE_N = 1'h1;
	// Reset value of the channel-group select synchroniser (group A).
	localparam logic GROUP_A    = 1'h0;
	// Reset value of the result bus register.
	localparam logic [SAMPLE_W-1:0] DATA_RESET = '0;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_SLEEP,
		ST_CONVERT,
		ST_FIRST,
		ST_SECOND
	} dspadc_state_t;

endpackage : dspadc_pkg

// ### core/dspadc_stream_if.sv
`timescale 1ns/100ps
// Valid/ready word stream between the sequencer, the buffer and the read port.
interface dspadc_stream_if #(
	parameter int W = dspadc_pkg::SAMPLE_W
);
	logic         valid;  // Source offers a word.
	logic         ready;  // Sink takes the word this cycle if valid.
	logic [W-1:0] data;   // Offered word.

	// Side that produces words.
	modport src (output valid, output data, input ready);
	// Side that consumes words.
	modport snk (input valid, input data, output ready);
endinterface : dspadc_stream_if

// ### core/dspadc_top.sv
`timescale 1ns/100ps
// Operation
// - start holds both inputs and converts together
// - busy falling marks both results ready
// - group select level picks group A or B
// - first read returns the group's first input
// - second read returns the group's second input
// - 14-bit bus, qualified by chip select and read
// - results ready within 5.2 us of start unless the result buffer is full
// - power down after conversion, wake at start
module dspadc_top #(
	parameter int DATA_W     = dspadc_pkg::SAMPLE_W,
	parameter int FIFO_DEPTH = dspadc_pkg::FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              conversionStartN,
	input  wire logic              channelGroupSelect,
	input  wire logic              chipSelectN,
	input  wire logic              readStrobeN,
	input  wire logic [DATA_W-1:0] groupAFirstInput,
	input  wire logic [DATA_W-1:0] groupASecondInput,
	input  wire logic [DATA_W-1:0] groupBFirstInput,
	input  wire logic [DATA_W-1:0] groupBSecondInput,
	output logic                   busy,
	output logic                   powerDown,
	output logic      [DATA_W-1:0] dataOut,
	output logic                   dataOe
);
	import dspadc_pkg::*;

	// Picks the group B word when the select is high, else the group A word.
	function automatic logic [DATA_W-1:0] pickGroup(
		input logic              sel,
		input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b
	);
		return sel ? b : a;
	endfunction : pickGroup

	// Pin synchronisers; the first stage of each feeds only the second.
	logic startMeta;        // Start pin, first stage.
	logic startSync;        // Start pin, synchronised.
	logic startPrev;        // Start pin, one cycle older, for the edge.
	logic selMeta;          // Group select, first stage.
	logic selSync;          // Group select, synchronised.
	logic csMeta;           // Chip select, first stage.
	logic csSync;           // Chip select, synchronised.
	logic rdMeta;           // Read strobe, first stage.
	logic rdSync;           // Read strobe, synchronised.
	logic readPrev;         // Read window, one cycle older.

	// Derived events.
	logic startPulse;       // Falling edge of the start pin.
	logic readActive;       // Chip select and read strobe both low.
	logic readPulse;        // First cycle of a read window.

	// Sequencer.
	dspadc_state_t   state;         // Current phase of a conversion.
	logic [CNT_W-1:0] convCount;    // Cycles spent converting.
	logic [DATA_W-1:0] heldFirst;   // Held first input of the chosen group.
	logic [DATA_W-1:0] heldSecond;  // Held second input of the chosen group.
	logic              heldSel;     // Group chosen at the start.
	logic              pushFire;    // A result enters the buffer.

	// Streams into and out of the result buffer.
	dspadc_stream_if #(.W(DATA_W)) pushBus ();
	dspadc_stream_if #(.W(DATA_W)) popBus ();

	// Two flip-flops on every control pin before any logic reads it; the group inputs are sampled directly.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			startMeta <= PIN_IDLE_N;
			startSync <= PIN_IDLE_N;
			startPrev <= PIN_IDLE_N;
			selMeta   <= GROUP_A;
			selSync   <= GROUP_A;
			csMeta    <= PIN_IDLE_N;
			csSync    <= PIN_IDLE_N;
			rdMeta    <= PIN_IDLE_N;
			rdSync    <= PIN_IDLE_N;
			readPrev  <= 1'h0;
		end else begin
			startMeta <= conversionStartN;
			startSync <= startMeta;
			startPrev <= startSync;
			selMeta   <= channelGroupSelect;
			selSync   <= selMeta;
			csMeta    <= chipSelectN;
			csSync    <= csMeta;
			rdMeta    <= readStrobeN;
			rdSync    <= rdMeta;
			readPrev  <= readActive;
		end
	end

	// A start is the high-to-low change of the synchronised pin.
	assign startPulse = startPrev && !startSync;
	// A transfer exists only while both strobes are low.
	assign readActive = !csSync && !rdSync;
	assign readPulse  = readActive && !readPrev;

	// Phase sequence: sleep, convert, write first result, write second.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_SLEEP;
		end else begin
			unique case (state)
				ST_SLEEP: begin
					// Starts during a conversion are ignored.
					if (startPulse) begin
						state <= ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (convCount == CONV_LAST) begin
						state <= ST_FIRST;
					end
				end
				ST_FIRST: begin
					// A full buffer stalls here until the host reads.
					if (pushFire) begin
						state <= ST_SECOND;
					end
				end
				ST_SECOND: begin
					if (pushFire) begin
						state <= ST_SLEEP;
					end
				end
			endcase
		end
	end

	// Counts the converting phase; restarts at each accepted start.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			convCount <= CNT_ZERO;
		end else if (state == ST_SLEEP) begin
			convCount <= CNT_ZERO;
		end else if (state == ST_CONVERT) begin
			convCount <= CNT_W'(convCount + 1'h1);
		end
	end

	// Both track/holds go to hold on the same edge with the chosen group.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			heldFirst  <= DATA_RESET;
			heldSecond <= DATA_RESET;
			heldSel    <= GROUP_A;
		end else if (state == ST_SLEEP && startPulse) begin
			heldFirst  <= pickGroup(selSync, groupAFirstInput, groupBFirstInput);
			heldSecond <= pickGroup(selSync, groupASecondInput, groupBSecondInput);
			heldSel    <= selSync;
		end
	end

	// First result enters the buffer before the second, fixing read order.
	assign pushBus.valid = (state == ST_FIRST) || (state == ST_SECOND);
	assign pushBus.data  = (state == ST_FIRST) ? heldFirst : heldSecond;
	assign pushFire      = pushBus.valid && pushBus.ready;

	// Busy covers the whole conversion until both results are stored.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'h0;
		end else if (state == ST_SLEEP && startPulse) begin
			busy <= 1'h1;
		end else if (state == ST_SECOND && pushFire) begin
			busy <= 1'h0;
		end
	end

	// Powered down out of reset and after each conversion, awake while busy.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			powerDown <= 1'h1;
		end else if (state == ST_SLEEP && startPulse) begin
			powerDown <= 1'h0;
		end else if (state == ST_SECOND && pushFire) begin
			powerDown <= 1'h1;
		end
	end

	// Result buffer between the converter and the read port.
	dspadc_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk     (clk),
		.rst     (rst),
		.inPort  (pushBus),
		.outPort (popBus)
	);

	// Each read window takes one word from the buffer, none when it is empty.
	assign popBus.ready = readPulse;

	// Latches the word for the read window; an empty buffer repeats the last.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dataOut <= DATA_RESET;
		end else if (readPulse && popBus.valid) begin
			dataOut <= popBus.data;
		end
	end

	// The bus is driven only while both strobes are seen low.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dataOe <= 1'h0;
		end else begin
			dataOe <= readActive;
		end
	end

	// Checks on the sequencing and the read port.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Helper: busy cycle counter and a flag for a stall on a full buffer.
	logic [CNT_W:0] busyCycles;  // Edges since busy rose.
	logic           stalled;     // Buffer refused a result in this conversion.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busyCycles <= '0;
			stalled    <= 1'h0;
		end else if (!busy) begin
			busyCycles <= '0;
			stalled    <= 1'h0;
		end else begin
			busyCycles <= (CNT_W + 1)'(busyCycles + 1'h1);
			if (pushBus.valid && !pushBus.ready) begin
				stalled <= 1'h1;
			end
		end
	end

	// An accepted start.
	sequence s_start;
		state == ST_SLEEP && startPulse;
	endsequence
	// Both holds taken from one group on the next edge.
	sequence s_holdBoth;
		heldFirst == pickGroup($past(selSync), $past(groupAFirstInput),
			$past(groupBFirstInput))
		&& heldSecond == pickGroup($past(selSync), $past(groupASecondInput),
			$past(groupBSecondInput));
	endsequence

	property p_holdBoth;
		s_start |=> s_holdBoth and (busy && state == ST_CONVERT);
	endproperty
	a_holdBoth: assert property (p_holdBoth) else $error("Holds not taken together.");

	property p_busyEnd;
		$fell(busy) |-> $past(state) == ST_SECOND && $past(pushFire);
	endproperty
	a_busyEnd: assert property (p_busyEnd) else $error("Busy fell before results stored.");

	property p_groupSel;
		s_start |=> heldSel == $past(selSync);
	endproperty
	a_groupSel: assert property (p_groupSel) else $error("Group select not followed.");

	property p_firstWord;
		state == ST_FIRST && pushFire |-> pushBus.data == heldFirst ##1 state == ST_SECOND;
	endproperty
	a_firstWord: assert property (p_firstWord) else $error("First result out of order.");

	property p_secondWord;
		state == ST_SECOND && pushFire |-> pushBus.data == heldSecond ##1 !busy;
	endproperty
	a_secondWord: assert property (p_secondWord) else $error("Second result out of order.");

	property p_oeQualified;
		dataOe |-> $past(readActive);
	endproperty
	a_oeQualified: assert property (p_oeQualified) else $error("Bus driven outside a read.");

	property p_convTime;
		busy && !stalled |-> busyCycles < (CNT_W + 1)'(CONV_CYCLES);
	endproperty
	a_convTime: assert property (p_convTime) else $error("Conversion too slow.");

	property p_powerCycle;
		($fell(busy) |-> powerDown) and ($rose(busy) |-> !powerDown);
	endproperty
	a_powerCycle: assert property (p_powerCycle) else $error("Power-down state wrong.");

	property p_busRelease;
		!readActive [*2] |-> !dataOe;
	endproperty
	a_busRelease: assert property (p_busRelease) else $error("Bus not released.");

	property p_onePop;
		popBus.ready |=> !popBus.ready;
	endproperty
	a_onePop: assert property (p_onePop) else $error("Two pops in one read.");
endmodule : dspadc_top

// ### verif/dspadc_host_model.sv
`timescale 1ns/100ps
// Behavioural host processor that drives the start pin and the read strobes.
module dspadc_host_model (
	input  wire logic                          clk,
	input  wire logic [dspadc_pkg::SAMPLE_W-1:0] dataBus,
	output logic                               conversionStartN,
	output logic                               chipSelectN,
	output logic                               readStrobeN
);
	import dspadc_pkg::*;

	// All host pins idle high until the first access.
	initial begin
		conversionStartN = 1'h1;
		chipSelectN      = 1'h1;
		readStrobeN      = 1'h1;
	end

	// Pulses the start pin low for four cycles, then leaves it high.
	task automatic startConv();
		@(negedge clk);
		conversionStartN = 1'h0;
		repeat (4) @(negedge clk);
		conversionStartN = 1'h1;
	endtask : startConv

	// Reads one word: both strobes low for five cycles, sample, release, recover.
	task automatic readWord(output logic [SAMPLE_W-1:0] w);
		@(negedge clk);
		chipSelectN = 1'h0;
		readStrobeN = 1'h0;
		repeat (5) @(posedge clk);
		w = dataBus;
		@(negedge clk);
		chipSelectN = 1'h1;
		readStrobeN = 1'h1;
		repeat (4) @(negedge clk);
	endtask : readWord
endmodule : dspadc_host_model

// ### verif/dspadc_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the converter host port with a queue model of results.
module dspadc_tb_top;
	import dspadc_pkg::*;

	logic                clk;              // System clock.
	logic                rst;              // Asynchronous reset.
	logic                conversionStartN; // Start pin from the host.
	logic                chipSelectN;      // Chip select from the host.
	logic                readStrobeN;      // Read strobe from the host.
	logic                groupSel;         // Channel-group select.
	logic [SAMPLE_W-1:0] aFirst;           // Group A first input.
	logic [SAMPLE_W-1:0] aSecond;          // Group A second input.
	logic [SAMPLE_W-1:0] bFirst;           // Group B first input.
	logic [SAMPLE_W-1:0] bSecond;          // Group B second input.
	logic                busy;             // Conversion in progress.
	logic                powerDown;        // Converter asleep.
	logic [SAMPLE_W-1:0] dataOut;          // Driven result word.
	logic                dataOe;           // Bus drive enable.
	logic [SAMPLE_W-1:0] dataBus;          // Resolved bus seen by the host.
	logic [SAMPLE_W-1:0] expQ[$];          // Words expected at the read port.
	logic [SAMPLE_W-1:0] lastWord;         // Last word read, repeated when empty.
	integer              seed;             // Random seed.
	int                  failures;         // Mismatch count.
	int                  totalChecks;      // Comparison count.
	int                  cycles;           // Timeout counter.

	// An undriven bus shows the inverse of the last word, never a stale copy.
	assign dataBus = dataOe ? dataOut : ~dataOut;

	dspadc_top #(.DATA_W(SAMPLE_W), .FIFO_DEPTH(FIFO_DEPTH)) uut (
		.clk                (clk),
		.rst                (rst),
		.conversionStartN   (conversionStartN),
		.channelGroupSelect (groupSel),
		.chipSelectN        (chipSelectN),
		.readStrobeN        (readStrobeN),
		.groupAFirstInput   (aFirst),
		.groupASecondInput  (aSecond),
		.groupBFirstInput   (bFirst),
		.groupBSecondInput  (bSecond),
		.busy               (busy),
		.powerDown          (powerDown),
		.dataOut            (dataOut),
		.dataOe             (dataOe)
	);

	dspadc_host_model host (
		.clk              (clk),
		.dataBus          (dataBus),
		.conversionStartN (conversionStartN),
		.chipSelectN      (chipSelectN),
		.readStrobeN      (readStrobeN)
	);

	// Clock of 20 ns period.
	initial clk = 1'h0;
	always #10 clk = ~clk;

	// Cuts a hang short well above the expected run length.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			end_sim();
		end
	end

	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks = totalChecks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Puts new random values on the inputs and the group select.
	task automatic scramble();
		@(negedge clk);
		aFirst   = $random(seed);
		aSecond  = $random(seed);
		bFirst   = $random(seed);
		bSecond  = $random(seed);
		groupSel = $random(seed);
	endtask : scramble

	// Reads one word and compares it with the model, then checks the bus is released.
	task automatic readCheck();
		logic [SAMPLE_W-1:0] w;
		logic [SAMPLE_W-1:0] e;
		host.readWord(w);
		e = (expQ.size() > 0) ? expQ.pop_front() : lastWord;
		check(w, e);
		lastWord = e;
		check(dataOe, 32'h0);
	endtask : readCheck

	// One conversion; optional ignored restart and optional full-buffer stall.
	task automatic convert(input bit again, input bit stall);
		int n;
		int hi;
		scramble();
		expQ.push_back(groupSel ? bFirst : aFirst);
		expQ.push_back(groupSel ? bSecond : aSecond);
		fork host.startConv(); join_none
		n = 0;
		while (busy !== 1'h1 && n < 10) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(busy, 32'h1);
		hi = 0;
		while (busy === 1'h1 && hi < 400) begin
			check(powerDown, 32'h0);
			// Inputs and select change after the start; results must not follow.
			if (hi == 5) fork scramble(); join_none
			if (again && hi == 20) fork host.startConv(); join_none
			@(posedge clk);
			#1;
			hi++;
		end
		check(hi, stall ? 32'h190 : CONV_CYCLES);
		if (stall) begin
			// Two reads make room, so the stalled conversion may finish.
			readCheck();
			readCheck();
			n = 0;
			while (busy === 1'h1 && n < 20) begin
				@(posedge clk);
				#1;
				n++;
			end
			check(busy, 32'h0);
		end
		check(powerDown, 32'h1);
	endtask : convert

	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	// Main sequence.
	initial begin
		seed        = 86;
		failures    = 0;
		totalChecks = 0;
		cycles      = 0;
		lastWord    = '0;
		rst         = 1'h1;
		groupSel    = 1'h0;
		aFirst      = '0;
		aSecond     = '0;
		bFirst      = '0;
		bSecond     = '0;
		repeat (5) @(negedge clk);
		rst = 1'h0;
		check(busy, 32'h0);
		check(powerDown, 32'h1);
		check(dataOe, 32'h0);
		check(dataOut, 32'h0);
		// Plain conversions, each read back twice; the second restarts while busy.
		for (int i = 0; i < 4; i++) begin
			convert(i == 1, 1'b0);
			readCheck();
			readCheck();
		end
		// Fill the buffer, stall one conversion, then drain past empty.
		for (int i = 0; i < 16; i++) begin
			convert(1'b0, 1'b0);
		end
		convert(1'b0, 1'b1);
		for (int i = 0; i < 33; i++) begin
			readCheck();
		end
		end_sim();
	end
endmodule : dspadc_tb_top
